// ### csc_pkg.sv
// Function
// - Count programmed wait states before internal acknowledge.
// - External acknowledge overrides internal one, ends cycle.
// - Internal acknowledge only when auto-acknowledge set.
// - Early external acknowledge ends the cycle immediately.
// - Burst advances address after each beat termination.
// - Port width selects the data lanes used.
// - Lane mode clear: no strobes on reads.
// - Lane mode set: lane selects on reads.
// - Burst read off: split wide reads into beats.
// - Burst read on: wide reads run as bursts.
// - Burst write off: split wide writes into beats.
// - Burst write on: wide writes run as bursts.
// - Region 0 resets to full waits, strapped fields.
// - Region 0 is global select out of reset.
// - Region selects only when valid, except global.
package csc_pkg;

  localparam int NREG = 8;

  // Register indices; the APB byte address is four times the index.
  localparam logic [7:0] CTRL_IDX [NREG] = '{8'h8a, 8'h96, 8'ha2, 8'hae, 8'hba, 8'hc6, 8'hd2, 8'hde};
  localparam logic [7:0] STATUS_IDX      = 8'he0;

  localparam logic [15:0] CTRL_WR_MASK   = 16'h3df8;
  localparam logic [15:0] CTRL0_RST      = 16'h3c00;
  localparam logic [15:0] CTRL_OTHER_RST = 16'h0000;

  localparam int STRAP_AUTO_BIT  = 7;
  localparam int STRAP_PW_HI_BIT = 6;
  localparam int STRAP_PW_LO_BIT = 5;

  localparam logic [1:0] PW_32 = 2'b00;
  localparam logic [1:0] PW_8  = 2'b01;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10,
    SZ_LINE = 2'b11
  } xfer_size_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BEAT = 2'b01,
    ST_GAP  = 2'b10
  } cyc_state_t;

  typedef struct packed {
    logic [1:0] reserved_hi;
    logic [3:0] wait_count;
    logic       reserved_9;
    logic       auto_ack_enable;
    logic [1:0] port_width;
    logic       byte_lane_mode;
    logic       burst_read_enable;
    logic       burst_write_enable;
    logic [2:0] reserved_lo;
  } ctrl_t;

  typedef struct packed {
    logic         write;
    xfer_size_t   size;
    logic [31:0]  addr;
    logic [127:0] wdata;
  } req_t;

endpackage

// ### chip_select_cycle_control.sv
`timescale 1ns/1ns
`default_nettype none
module chip_select_cycle_control
  import csc_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [11:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         req_valid,
  input  wire req_t         req,
  output logic              req_ready,
  output logic              resp_done,
  output logic              resp_miss,
  output logic      [127:0] resp_rdata,
  input  wire logic [7:0]   region_hit,
  input  wire logic [7:0]   region_valid,
  output logic      [7:0]   region_select_n,
  output logic              global_boot_select,
  output logic      [31:0]  ext_addr,
  output logic              ext_write,
  output logic              burst_active,
  output logic      [31:0]  ext_data_out,
  output logic              ext_data_oe,
  input  wire logic [31:0]  ext_data_in,
  input  wire logic         ext_ack,
  output logic              cycle_done_acknowledge,
  output logic      [3:0]   byte_lane_select,
  output logic      [3:0]   byte_write_strobe
);

  // ==========================================================================
  // Helpers
  function automatic logic [4:0] size_bytes(input xfer_size_t s);
    case (s)
      SZ_BYTE: size_bytes = 5'h01;
      SZ_WORD: size_bytes = 5'h02;
      SZ_LONG: size_bytes = 5'h04;
      default: size_bytes = 5'h10;
    endcase
  endfunction

  function automatic logic [2:0] port_bytes(input logic [1:0] pw);
    if (pw == PW_32) begin
      port_bytes = 3'h4;
    end else if (pw == PW_8) begin
      port_bytes = 3'h1;
    end else begin
      port_bytes = 3'h2;
    end
  endfunction

  function automatic logic [1:0] lane_offset(input logic [1:0] pw, input logic [31:0] a);
    if (pw == PW_32) begin
      lane_offset = a[1:0];
    end else if (pw == PW_8) begin
      lane_offset = 2'h0;
    end else begin
      lane_offset = {1'b0, a[0]};
    end
  endfunction

  function automatic logic [3:0] lane_mask(input logic [2:0] bb, input logic [1:0] off);
    logic [3:0] m;
    m = (bb == 3'h4) ? 4'hf : ((bb == 3'h2) ? 4'hc : 4'h8);
    lane_mask = m >> off;
  endfunction

  // ==========================================================================
  // Registers and state
  ctrl_t        ctrl_ff [NREG];
  logic         strap_done_ff;
  logic         global_ff;
  logic [31:0]  prdata_ff;
  cyc_state_t   state_ff;
  ctrl_t        cur_ctrl_ff;
  logic [2:0]   cur_region_ff;
  logic         write_ff;
  logic         burst_ff;
  logic [4:0]   beats_ff;
  logic [3:0]   cnt_ff;
  logic [3:0]   beat_age_ff;
  logic [31:0]  addr_ff;
  logic [127:0] data_ff;
  logic [127:0] rd_ff;
  logic [2:0]   beat_bytes_ff;
  logic [1:0]   off_ff;
  logic [3:0]   lanes_ff;
  logic [31:0]  dout_ff;
  logic         done_ff;
  logic         miss_ff;

  // ==========================================================================
  // APB decode
  logic       slot_ok;
  logic [2:0] slot_idx;
  logic       stat_ok;
  logic       apb_setup;
  logic       apb_access;

  always_comb begin
    slot_ok  = 1'b0;
    slot_idx = 3'h0;
    for (int i = 0; i < NREG; i++) begin
      if (paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00 && paddr[9:2] == CTRL_IDX[i]) begin
        slot_ok  = 1'b1;
        slot_idx = 3'(i);
      end
    end
    stat_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) && (paddr[9:2] == STATUS_IDX);
  end

  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  assign pready     = 1'b1;
  assign pslverr    = apb_access && !(slot_ok || stat_ok);
  assign prdata     = prdata_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (apb_setup) begin
      if (slot_ok) begin
        prdata_ff <= {16'h0000, ctrl_ff[slot_idx] & CTRL_WR_MASK};
      end else if (stat_ok) begin
        prdata_ff <= {27'h000_0000, cur_region_ff, global_ff, (state_ff != ST_IDLE)};
      end else begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Control registers; region 0 takes its strapped fields after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_ff <= 1'b0;
      for (int i = 0; i < NREG; i++) begin
        ctrl_ff[i] <= (i == 0) ? ctrl_t'(CTRL0_RST) : ctrl_t'(CTRL_OTHER_RST);
      end
    end else begin
      if (!strap_done_ff) begin
        strap_done_ff              <= 1'b1;
        ctrl_ff[0].auto_ack_enable <= ext_data_in[STRAP_AUTO_BIT];
        ctrl_ff[0].port_width      <= {ext_data_in[STRAP_PW_HI_BIT], ext_data_in[STRAP_PW_LO_BIT]};
      end
      if (apb_access && pwrite && slot_ok) begin
        ctrl_ff[slot_idx] <= ctrl_t'(pwdata[15:0] & CTRL_WR_MASK);
      end
    end
  end

  // Region 0 answers every address that no valid region hits until software validates it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_ff <= 1'b1;
    end else if (region_valid[0]) begin
      global_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Region pick and beat preparation
  logic [7:0]   hit_vec;
  logic         any_valid;
  logic         use_global;
  logic         accept_ok;
  logic [2:0]   pick_idx;
  ctrl_t        ld_ctrl;
  logic [31:0]  ld_addr;
  logic [127:0] ld_data;
  logic [4:0]   ld_sb;
  logic [2:0]   ld_pb;
  logic [2:0]   ld_bb;
  logic [4:0]   ld_beats;
  logic [1:0]   ld_off;
  logic         ld_burst;
  logic         idle;
  logic         beat_end;
  logic         int_ack;

  assign hit_vec    = region_hit & region_valid;
  assign any_valid  = |hit_vec;
  assign use_global = !any_valid && global_ff;
  assign accept_ok  = any_valid || use_global;
  assign idle       = (state_ff == ST_IDLE);

  always_comb begin
    pick_idx = 3'h0;
    for (int i = NREG - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        pick_idx = 3'(i);
      end
    end
  end

  always_comb begin
    ld_ctrl = idle ? ctrl_ff[pick_idx] : cur_ctrl_ff;
    ld_sb   = size_bytes(req.size);
    ld_pb   = port_bytes(ld_ctrl.port_width);
    if (idle) begin
      ld_addr = req.addr;
      ld_data = req.wdata << {(5'h10 - ld_sb), 3'b000};
    end else begin
      ld_addr = addr_ff + {29'h000_0000, beat_bytes_ff};
      ld_data = data_ff << {beat_bytes_ff, 3'b000};
    end
    ld_bb = ({2'b00, ld_pb} < ld_sb) ? ld_pb : ld_sb[2:0];
    case (ld_bb)
      3'h1:    ld_beats = ld_sb;
      3'h2:    ld_beats = ld_sb >> 1;
      default: ld_beats = ld_sb >> 2;
    endcase
    ld_off   = lane_offset(ld_ctrl.port_width, ld_addr);
    ld_burst = (ld_beats > 5'h01) &&
               (req.write ? ld_ctrl.burst_write_enable : ld_ctrl.burst_read_enable);
  end

  // An outside acknowledge ends the beat whatever the count shows.
  assign beat_end = (state_ff == ST_BEAT) &&
                    (ext_ack || (cur_ctrl_ff.auto_ack_enable && cnt_ff == 4'h0));
  assign int_ack  = (state_ff == ST_BEAT) && cur_ctrl_ff.auto_ack_enable &&
                    (cnt_ff == 4'h0) && !ext_ack;

  // ==========================================================================
  // Cycle sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff      <= ST_IDLE;
      cur_ctrl_ff   <= ctrl_t'(CTRL_OTHER_RST);
      cur_region_ff <= 3'h0;
      write_ff      <= 1'b0;
      burst_ff      <= 1'b0;
      beats_ff      <= 5'h00;
      cnt_ff        <= 4'h0;
      beat_age_ff   <= 4'h0;
      addr_ff       <= 32'h0000_0000;
      data_ff       <= '0;
      beat_bytes_ff <= 3'h0;
      off_ff        <= 2'h0;
      lanes_ff      <= 4'h0;
      dout_ff       <= 32'h0000_0000;
      done_ff       <= 1'b0;
      miss_ff       <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      miss_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (req_valid && accept_ok) begin
            state_ff      <= ST_BEAT;
            cur_ctrl_ff   <= ld_ctrl;
            cur_region_ff <= pick_idx;
            write_ff      <= req.write;
            burst_ff      <= ld_burst;
            beats_ff      <= ld_beats;
            cnt_ff        <= ld_ctrl.wait_count;
            beat_age_ff   <= 4'h0;
            addr_ff       <= ld_addr;
            data_ff       <= ld_data;
            beat_bytes_ff <= ld_bb;
            off_ff        <= ld_off;
            lanes_ff      <= lane_mask(ld_bb, ld_off);
            dout_ff       <= ld_data[127:96] >> {ld_off, 3'b000};
          end else if (req_valid) begin
            miss_ff <= 1'b1;
          end
        end
        ST_BEAT: begin
          if (beat_end) begin
            if (beats_ff == 5'h01) begin
              state_ff <= ST_IDLE;
              done_ff  <= 1'b1;
              burst_ff <= 1'b0;
            end else begin
              state_ff      <= burst_ff ? ST_BEAT : ST_GAP;
              beats_ff      <= beats_ff - 5'h01;
              cnt_ff        <= cur_ctrl_ff.wait_count;
              beat_age_ff   <= 4'h0;
              addr_ff       <= ld_addr;
              data_ff       <= ld_data;
              off_ff        <= ld_off;
              lanes_ff      <= lane_mask(beat_bytes_ff, ld_off);
              dout_ff       <= ld_data[127:96] >> {ld_off, 3'b000};
            end
          end else begin
            if (cnt_ff != 4'h0) begin
              cnt_ff <= cnt_ff - 4'h1;
            end
            if (beat_age_ff != 4'hf) begin
              beat_age_ff <= beat_age_ff + 4'h1;
            end
          end
        end
        ST_GAP: begin
          state_ff <= ST_BEAT;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Read beats are gathered big end first, right justified in the result.
  logic [31:0] rd_val;
  logic [31:0] rd_piece;
  assign rd_val   = ext_data_in << {off_ff, 3'b000};
  assign rd_piece = rd_val >> {(3'h4 - beat_bytes_ff), 3'b000};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ff <= '0;
    end else if (idle && req_valid && accept_ok) begin
      rd_ff <= '0;
    end else if (beat_end && !write_ff) begin
      rd_ff <= (rd_ff << {beat_bytes_ff, 3'b000}) | {{96{1'b0}}, rd_piece};
    end
  end

  // ==========================================================================
  // Outputs
  logic beat_on;
  assign beat_on                = (state_ff == ST_BEAT);
  assign req_ready              = idle;
  assign resp_done              = done_ff;
  assign resp_miss              = miss_ff;
  assign resp_rdata             = rd_ff;
  assign global_boot_select     = global_ff;
  assign region_select_n        = beat_on ? ~(8'h01 << cur_region_ff) : 8'hff;
  assign ext_addr               = addr_ff;
  assign ext_write              = beat_on && write_ff;
  assign burst_active           = burst_ff;
  assign ext_data_out           = dout_ff;
  assign ext_data_oe            = beat_on && write_ff;
  assign cycle_done_acknowledge = int_ack;
  assign byte_write_strobe      = (beat_on && write_ff) ? lanes_ff : 4'h0;
  assign byte_lane_select       = (beat_on && !write_ff && cur_ctrl_ff.byte_lane_mode) ? lanes_ff : 4'h0;

  // ==========================================================================
  // Checks
  a_wait_full_count: assert property (@(posedge pclk) disable iff (!presetn)
    cycle_done_acknowledge |-> beat_age_ff == cur_ctrl_ff.wait_count)
    else $error("internal acknowledge not after the programmed wait count");

  a_ext_ack_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (beat_on && ext_ack) |-> !cycle_done_acknowledge ##1 (state_ff != ST_BEAT || beat_age_ff == 4'h0))
    else $error("external acknowledge did not end the beat");

  a_no_auto_ack: assert property (@(posedge pclk) disable iff (!presetn)
    (beat_on && !cur_ctrl_ff.auto_ack_enable && !ext_ack) |=> (state_ff == ST_BEAT && !cycle_done_acknowledge))
    else $error("beat ended without external acknowledge");

  a_early_ext_end: assert property (@(posedge pclk) disable iff (!presetn)
    (beat_on && ext_ack && cnt_ff != 4'h0 && beats_ff == 5'h01) |=> resp_done && req_ready)
    else $error("early external acknowledge did not finish the transfer");

  a_burst_addr_step: assert property (@(posedge pclk) disable iff (!presetn)
    (beat_end && beats_ff > 5'h01) |=> ext_addr == $past(ext_addr) + {29'h000_0000, beat_bytes_ff})
    else $error("address did not advance by the beat size");

  a_narrow_lanes: assert property (@(posedge pclk) disable iff (!presetn)
    (beat_on && cur_ctrl_ff.port_width == PW_8) |-> ((byte_write_strobe | byte_lane_select) & 4'h7) == 4'h0)
    else $error("byte port used a lane other than the top one");

  a_read_no_strobe: assert property (@(posedge pclk) disable iff (!presetn)
    (beat_on && !write_ff && !cur_ctrl_ff.byte_lane_mode) |-> (byte_lane_select == 4'h0 && byte_write_strobe == 4'h0))
    else $error("strobes on a read with lane mode clear");

  a_read_lane_sel: assert property (@(posedge pclk) disable iff (!presetn)
    (beat_on && !write_ff && cur_ctrl_ff.byte_lane_mode) |-> (byte_lane_select == lanes_ff && lanes_ff != 4'h0))
    else $error("lane selects missing on a read with lane mode set");

  a_split_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (beat_end && !burst_ff && beats_ff > 5'h01) |=> region_select_n == 8'hff ##1 region_select_n != 8'hff)
    else $error("split transfer did not drop the select between beats");

  a_burst_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (beat_end && burst_ff && beats_ff > 5'h01) |=> region_select_n == $past(region_select_n))
    else $error("burst dropped the select between beats");

  a_boot_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(strap_done_ff) |-> (ctrl_ff[0].wait_count == 4'hf && ctrl_ff[0].auto_ack_enable == $past(ext_data_in[7])))
    else $error("region 0 reset fields wrong");

  a_global_boot: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && req_ready && use_global) |=> region_select_n == 8'hfe)
    else $error("global select did not take the cycle");

  a_valid_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && req_ready && !any_valid && !global_ff) |=> (resp_miss && region_select_n == 8'hff))
    else $error("select asserted without a valid region");

endmodule
`default_nettype wire

// ### ext_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model
  import csc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  region_select_n,
  input  wire logic [31:0] ext_addr,
  input  wire logic        ext_write,
  input  wire logic [31:0] ext_data_out,
  input  wire logic [3:0]  byte_write_strobe,
  input  wire logic        cycle_done_acknowledge,
  input  wire logic [1:0]  port_width,
  input  wire logic        ack_en,
  input  wire logic [2:0]  ack_delay,
  input  wire logic        strap_en,
  input  wire logic [2:0]  strap,
  output logic      [31:0] ext_data_in,
  output logic             ext_ack
);
  // ==========
  // Memory behind the select; bus lane j from the top carries the byte at base plus j.
  logic [7:0]  mem_ff [256];
  logic [31:0] last_ff;
  logic [2:0]  cnt_ff;
  logic [7:0]  base;
  logic        sel;
  logic        beat_end;

  assign sel      = ~&region_select_n;
  assign beat_end = sel && (ext_ack || cycle_done_acknowledge);
  assign base     = (port_width == PW_8) ? ext_addr[7:0] :
                    (port_width == PW_32) ? {ext_addr[7:2], 2'h0} : {ext_addr[7:1], 1'h0};
  // Released lines show the inverse of their last value, so stale data never passes for fresh.
  assign ext_data_in = strap_en ? {24'h00_0000, strap, 5'h00} :
                       (sel && !ext_write) ?
                       {mem_ff[base], mem_ff[base + 8'h01], mem_ff[base + 8'h02], mem_ff[base + 8'h03]} :
                       ~last_ff;
  // The far side ends each beat itself after ack_delay cycles when told to.
  assign ext_ack = ack_en && sel && (cnt_ff == ack_delay);

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem_ff[i] = 8'(i) ^ 8'h5a;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= 3'h0;
      last_ff <= 32'h0000_0000;
    end else begin
      last_ff <= ext_data_in;
      cnt_ff  <= (!sel || beat_end) ? 3'h0 : cnt_ff + 3'h1;
    end
  end

  always @(posedge pclk) begin
    for (int j = 0; j < 4; j++) begin
      if (beat_end && ext_write && byte_write_strobe[3 - j]) begin
        mem_ff[base + 8'(j)] <= ext_data_out[8 * (3 - j) +: 8];
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
  import csc_pkg::*;
;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid, req_ready;
  logic         resp_done, resp_miss, global_boot_select, ext_write, burst_active, ext_data_oe;
  logic         ext_ack, cycle_done_acknowledge, ack_en, strap_en, ak, blm, br, bw, err, exp_wr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, ext_addr, ext_data_out, ext_data_in, exp_base, rd, a;
  logic [127:0] resp_rdata, wd;
  logic [7:0]   region_hit, region_valid, region_select_n;
  logic [3:0]   byte_lane_select, byte_write_strobe, w;
  logic [2:0]   ack_delay, strap;
  logic [1:0]   mem_pw, pw, sz;
  logic [15:0]  ctl;
  logic [7:0]   ref_mem [256];
  req_t         req;
  int           n_errors, comparisons, sel_cyc, beats, cda_n, bls_n, bws_n, burst_n, exp_bb, exp_reg, nb;

  chip_select_cycle_control dut (.*);
  ext_mem_model mem (.port_width(mem_pw), .*);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ==========
  // Checking and bus tasks.
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic final_report();
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wdat);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= wdat;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic start(input logic wr, input logic [1:0] s, input logic [31:0] ad, input logic [127:0] wdat);
    sel_cyc = 0;
    beats = 0;
    cda_n = 0;
    bls_n = 0;
    bws_n = 0;
    burst_n = 0;
    req <= '{write: wr, size: xfer_size_t'(s), addr: ad, wdata: wdat};
    req_valid <= 1'b1;
    @(posedge pclk);
    while (req_ready !== 1'b1) @(posedge pclk);
    req_valid <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic xfer(input logic wr, input logic [1:0] s, input logic [31:0] ad, input logic [127:0] wdat,
                      input logic [1:0] p, input logic auto, input logic [3:0] wc, input logic lane,
                      input logic bon);
    int n, bb, len;
    logic [127:0] exp;
    n = (s == 2'h3) ? 16 : (1 << s);
    bb = (p == PW_32) ? 4 : (p == PW_8) ? 1 : 2;
    bb = (bb > n) ? n : bb;
    exp_base = ad;
    exp_bb = bb;
    exp_wr = wr;
    start(wr, s, ad, wdat);
    while (resp_done !== 1'b1) @(posedge pclk);
    len = (auto && !ack_en) ? wc + 1 : ack_delay + 1;
    exp = '0;
    for (int j = 0; j < n; j++) begin
      if (wr) ref_mem[ad[7:0] + 8'(j)] = wdat[8 * (n - 1 - j) +: 8];
      exp = {exp[119:0], ref_mem[ad[7:0] + 8'(j)]};
    end
    if (!wr) chk(resp_rdata, exp, "read data");
    chk(beats, n / bb, "beat count");
    chk(sel_cyc, (n / bb) * len, "select cycles");
    chk(cda_n, (auto && !ack_en) ? n / bb : 0, "internal ack count");
    chk(burst_n != 0, (n > bb) && bon, "burst mode");
    chk(bls_n != 0, !wr && lane, "lane selects on read");
    chk(bws_n != 0, wr, "write strobes");
  endtask

  always @(posedge pclk) begin
    if (presetn && !(&region_select_n)) begin
      sel_cyc++;
      if (burst_active) burst_n++;
      if (byte_lane_select != 4'h0) bls_n++;
      if (byte_write_strobe != 4'h0) bws_n++;
      if (cycle_done_acknowledge) cda_n++;
      if (ext_ack || cycle_done_acknowledge) begin
        chk(ext_addr, exp_base + 32'(beats * exp_bb), "beat address");
        chk(region_select_n, 8'(~(8'h01 << exp_reg)), "region select");
        chk(ext_data_oe, exp_wr, "data drive enable");
        beats++;
      end
    end
  end

  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    final_report();
  end

  // ==========
  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, req_valid, req} = '0;
    {region_hit, region_valid, ack_en, ack_delay, n_errors, comparisons, exp_reg} = '0;
    mem_pw = PW_8;
    strap_en = 1'b1;
    strap = 3'h5;
    for (int i = 0; i < 256; i++) ref_mem[i] = 8'(i) ^ 8'h5a;
    void'($urandom(32'h2dd6e07e));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    strap_en <= 1'b0;
    @(posedge pclk);
    chk(global_boot_select, 1'b1, "global select after reset");
    for (int r = 0; r < NREG; r++) begin
      apb(1'b0, CTRL_IDX[r], 32'h0000_0000);
      chk(rd, (r == 0) ? {18'h0_000f, 1'b0, strap, 6'h00} : CTRL_OTHER_RST, "reset value");
    end
    apb(1'b0, STATUS_IDX, 32'h0000_0000);
    chk(rd, 32'h0000_0002, "status after reset");
    apb(1'b1, 8'h00, 32'hffff_ffff);
    chk(err, 1'b1, "unmapped write error");
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk({err, rd}, {1'b1, 32'h0000_0000}, "unmapped read error");
    wd = 128'($urandom);
    xfer(1'b1, 2'h2, 32'h0000_0040, wd, PW_8, 1'b1, 4'hf, 1'b0, 1'b0);
    xfer(1'b0, 2'h2, 32'h0000_0040, wd, PW_8, 1'b1, 4'hf, 1'b0, 1'b0);
    region_valid <= 8'h01;
    repeat (2) @(posedge pclk);
    chk(global_boot_select, 1'b0, "global select leaves");
    for (int k = 0; k < 2; k++) begin
      region_hit <= k ? 8'h04 : 8'h00;
      start(1'b0, 2'h0, 32'h0000_0010, '0);
      chk({resp_miss, 32'(sel_cyc)}, {1'b1, 32'h0}, "request without valid region");
    end
    region_valid <= 8'hff;
    repeat (40) begin
      exp_reg = $urandom_range(7);
      {pw, ak, blm, br, bw, sz} = 8'($urandom);
      ack_en <= !ak || $urandom_range(1);
      w = $urandom_range(15, 1);
      ack_delay <= ak ? $urandom_range(w > 7 ? 6 : w - 1) : $urandom_range(3);
      w = (ak && $urandom_range(3) == 0) ? 4'h0 : w;
      ctl = {2'b00, w, 1'b0, ak, pw, blm, br, bw, 3'b000};
      apb(1'b1, CTRL_IDX[exp_reg], {16'($urandom), ctl});
      apb(1'b0, CTRL_IDX[exp_reg], 32'h0000_0000);
      chk(rd, {18'h0_0000, ctl[13:10], 1'b0, ctl[8:3], 3'h0}, "control readback");
      if (w == 4'h0) ack_en <= 1'b0;
      region_hit <= 8'h01 << exp_reg;
      mem_pw <= pw;
      nb = (sz == 2'h3) ? 16 : (1 << sz);
      a = 32'($urandom_range(255) & ~(nb - 1));
      wd = {4{$urandom}} & ((128'h1 << (8 * nb)) - 128'h1);
      xfer(1'b1, sz, a, wd, pw, ak, w, blm, bw);
      xfer(1'b0, sz, a, wd, pw, ak, w, blm, br);
    end
    final_report();
  end
endmodule
`default_nettype wire
